// ---- rtim_core.v ----
/*
 Exception front end: reset type capture and release sequence, vector
 generation for reset, nonmaskable, pin, internal and trap exceptions,
 mask bit updates and the interrupt controller registers.
 Assumes an Avalon-MM master on the register side (8-bit data, byte
 addresses) and a CPU sequencer that acknowledges each vector with a pulse.
*/
`include "rtim_defs.vh"

module rtim_core (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire reset_in_n_i,
  input wire nmi_pin_i,
  input wire [7:0] ext_request_pins_i,
  input wire wdt_overflow_i,
  input wire wdt_manual_i,
  input wire advanced_mode_i,
  input wire [19:0] int_req_i,
  input wire [19:0] int_level_i,
  input wire trap_exec_i,
  input wire [1:0] trap_num_i,
  input wire sp_init_i,
  input wire vec_ack_i,
  input wire [15:0] stack_addr_i,
  input wire cpu_mask_i,
  input wire cpu_user_mask_i,
  input wire [15:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [7:0] avs_writedata_i,
  output reg [7:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output reg avs_response_err_o,
  output reg cpu_halt_o,
  output reg periph_reset_o,
  output reg port_reset_o,
  output reg pins_to_port_o,
  output reg vec_valid_o,
  output reg [6:0] vec_num_o,
  output reg [8:0] vec_addr_o,
  output reg set_mask_o,
  output reg set_user_mask_o,
  output reg [15:0] stack_addr_o,
  output reg [15:0] module_stop_ctrl_o,
  output reg [1:0] ctrl_mode_o
);

  localparam ST_RESET = 2'd0;
  localparam ST_VECTOR = 2'd1;
  localparam ST_RUN = 2'd2;

  // Shared by vector and address generation
  function [8:0] vec_addr;
    input [6:0] num;
    input adv;
    begin
      vec_addr = adv ? {num, 2'b00} : {1'b0, num, 1'b0};
    end
  endfunction

  function edge_hit;
    input [1:0] sense;
    input cur;
    input prev;
    begin
      case (sense)
        2'b00: edge_hit = ~cur;
        2'b01: edge_hit = prev & ~cur;
        2'b10: edge_hit = ~prev & cur;
        default: edge_hit = prev ^ cur;
      endcase
    end
  endfunction

  reg rst_q1;
  reg rst_q2;
  reg [2:0] pin_res;
  reg [2:0] pin_nmi;
  reg [7:0] pin_irq1;
  reg [7:0] pin_irq2;
  reg [7:0] pin_irq3;
  reg res_lvl;
  reg nmi_lvl;
  reg [7:0] irq_lvl;
  reg [1:0] state;
  reg manual_type;
  reg blocked;
  reg wdt_go;
  reg nmi_pend;
  reg trap_pend;
  reg [1:0] trap_num;
  reg [7:0] level_a;
  reg [7:0] level_b;
  reg [7:0] level_c;
  reg [7:0] sense_high;
  reg [7:0] sense_low;
  reg [7:0] req_enable;
  reg [7:0] req_flags;
  reg [7:0] sys_ctrl;
  reg [15:0] mstop;
  reg [7:0] next_flags;
  reg [7:0] rd;
  reg hit;
  reg [6:0] pick;
  reg pick_ok;
  reg pick_pri;
  integer i;
  integer j;

  wire ireset_n = rst_q2;
  wire res_rise = ~res_lvl & pin_res[2] & pin_res[1];
  wire nmi_chg = pin_nmi[2] == pin_nmi[1] && pin_nmi[1] != nmi_lvl;
  wire nmi_edge = nmi_chg & (sys_ctrl[`RTIM_SYSTEM_CONTROL_NMI_EDGE] ? ~nmi_lvl : nmi_lvl);
  wire mode1 = sys_ctrl[`RTIM_SYSTEM_CONTROL_MODE_LO] & ~sys_ctrl[`RTIM_SYSTEM_CONTROL_MODE_HI];
  wire bus_req = avs_read_i | avs_write_i;
  // Per pin: a bit moves only once its second and third stages agree
  wire [7:0] irq_now = ((pin_irq3 ~^ pin_irq2) & pin_irq2) | ((pin_irq3 ^ pin_irq2) & irq_lvl);
  wire [15:0] sense_all = {sense_high, sense_low};
  wire wr_flags = avs_write_i & avs_waitrequest_o == 1'b0 &&
    avs_address_i == `RTIM_OFS_REQ_FLAGS;

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Pin flags: hardware set wins over software clear
  always @* begin
    next_flags = req_flags;
    if (wr_flags)
      next_flags = req_flags & avs_writedata_i;
    for (i = 0; i < 8; i = i + 1)
      if (edge_hit(sense_all[2*i +: 2], irq_now[i], irq_lvl[i]))
        next_flags[i] = 1'b1;
  end

  // Pick highest priority request; mode 1 prefers level-1 sources
  always @* begin
    pick = 7'h00;
    pick_ok = 1'b0;
    pick_pri = 1'b0;
    for (j = 19; j >= 0; j = j - 1)
      if (int_req_i[j] && (!pick_ok || !(pick_pri && !int_level_i[j]))) begin
        if (!pick_ok || !mode1 || int_level_i[j] || !pick_pri) begin
          pick = `RTIM_VEC_INT_BASE + j[6:0];
          pick_ok = mode1 ? (!cpu_mask_i || (int_level_i[j] && !cpu_user_mask_i)) :
            !cpu_mask_i;
          pick_pri = mode1 & int_level_i[j];
        end
      end
    for (j = 7; j >= 0; j = j - 1)
      if (req_flags[j] & req_enable[j] &&
          (!pick_pri || level_a[7 - (j < 2 ? j : (j + 2) / 2)])) begin
        pick = `RTIM_VEC_EXT_BASE + j[6:0];
        pick_pri = mode1 & level_a[7 - (j < 2 ? j : (j + 2) / 2)];
        pick_ok = mode1 ? (!cpu_mask_i || (pick_pri && !cpu_user_mask_i)) : !cpu_mask_i;
      end
  end

  always @* begin
    hit = 1'b1;
    rd = 8'h00;
    case (avs_address_i)
      `RTIM_OFS_LEVEL_A: rd = level_a;
      `RTIM_OFS_LEVEL_B: rd = level_b;
      `RTIM_OFS_LEVEL_C: rd = level_c;
      `RTIM_OFS_SENSE_HIGH: rd = sense_high;
      `RTIM_OFS_SENSE_LOW: rd = sense_low;
      `RTIM_OFS_REQ_ENABLE: rd = req_enable;
      `RTIM_OFS_REQ_FLAGS: rd = req_flags;
      `RTIM_OFS_SYS_CTRL: rd = sys_ctrl;
      `RTIM_OFS_EXC_STATUS: rd = {4'h0, manual_type, blocked, state};
      `RTIM_OFS_MODULE_STOP: rd = mstop[7:0];
      `RTIM_OFS_EXC_CTRL: rd = mstop[15:8];
      default: hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i or negedge ireset_n) begin
    if (!ireset_n) begin
      pin_res <= 3'b000;
      pin_nmi <= 3'b000;
      pin_irq1 <= 8'hff;
      pin_irq2 <= 8'hff;
      pin_irq3 <= 8'hff;
      res_lvl <= 1'b0;
      nmi_lvl <= 1'b0;
      irq_lvl <= 8'hff;
      state <= ST_RESET;
      manual_type <= 1'b0;
      blocked <= 1'b1;
      nmi_pend <= 1'b0;
      trap_pend <= 1'b0;
      trap_num <= 2'b00;
      wdt_go <= 1'b0;
      level_a <= 8'h00;
      level_b <= 8'h00;
      level_c <= 8'h00;
      sense_high <= 8'h00;
      sense_low <= 8'h00;
      req_enable <= 8'h00;
      req_flags <= 8'h00;
      sys_ctrl <= `RTIM_SYSTEM_CONTROL_RESET;
      mstop <= `RTIM_MSTOP_RESET;
      avs_readdata_o <= 8'h00;
      avs_waitrequest_o <= 1'b1;
      avs_response_err_o <= 1'b0;
      cpu_halt_o <= 1'b1;
      periph_reset_o <= 1'b1;
      port_reset_o <= 1'b1;
      pins_to_port_o <= 1'b1;
      vec_valid_o <= 1'b0;
      vec_num_o <= 7'h00;
      vec_addr_o <= 9'h000;
      set_mask_o <= 1'b0;
      set_user_mask_o <= 1'b0;
      stack_addr_o <= 16'h0000;
      module_stop_ctrl_o <= `RTIM_MSTOP_RESET;
      ctrl_mode_o <= 2'b00;
    end else begin
      pin_res <= {pin_res[1:0], reset_in_n_i};
      pin_nmi <= {pin_nmi[1:0], nmi_pin_i};
      pin_irq1 <= ext_request_pins_i;
      pin_irq2 <= pin_irq1;
      pin_irq3 <= pin_irq2;
      irq_lvl <= irq_now;
      if (pin_res[2] == pin_res[1])
        res_lvl <= pin_res[2];
      if (pin_nmi[2] == pin_nmi[1])
        nmi_lvl <= pin_nmi[2];
      stack_addr_o <= {stack_addr_i[15:1], 1'b0};
      module_stop_ctrl_o <= mstop;
      ctrl_mode_o <= {sys_ctrl[`RTIM_SYSTEM_CONTROL_MODE_HI], sys_ctrl[`RTIM_SYSTEM_CONTROL_MODE_LO]};
      set_mask_o <= 1'b0;
      set_user_mask_o <= 1'b0;
      req_flags <= next_flags;
      if (nmi_edge && state == ST_RUN)
        nmi_pend <= 1'b1;
      if (trap_exec_i && state == ST_RUN) begin
        trap_pend <= 1'b1;
        trap_num <= trap_num_i;
      end
      if (sp_init_i)
        blocked <= 1'b0;
      // Bus slave: one wait cycle, then answer
      avs_waitrequest_o <= 1'b1;
      avs_response_err_o <= 1'b0;
      if (bus_req && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= rd;
        avs_response_err_o <= ~hit;
      end
      if (bus_req && !avs_waitrequest_o && avs_write_i) begin
        case (avs_address_i)
          `RTIM_OFS_LEVEL_A: level_a <= avs_writedata_i;
          `RTIM_OFS_LEVEL_B: level_b <= avs_writedata_i;
          `RTIM_OFS_LEVEL_C: level_c <= avs_writedata_i;
          `RTIM_OFS_SENSE_HIGH: sense_high <= avs_writedata_i;
          `RTIM_OFS_SENSE_LOW: sense_low <= avs_writedata_i;
          `RTIM_OFS_REQ_ENABLE: req_enable <= avs_writedata_i;
          `RTIM_OFS_SYS_CTRL:
            if (avs_writedata_i[5:4] != 2'b10)
              sys_ctrl <= (avs_writedata_i & `RTIM_SYSTEM_CONTROL_WMASK) | 8'h00;
          `RTIM_OFS_MODULE_STOP: mstop[7:0] <= avs_writedata_i;
          `RTIM_OFS_EXC_CTRL: mstop[15:8] <= avs_writedata_i;
          default: ;
        endcase
      end
      case (state)
        ST_RESET: begin
          cpu_halt_o <= 1'b1;
          vec_valid_o <= 1'b0;
          blocked <= 1'b1;
          nmi_pend <= 1'b0;
          trap_pend <= 1'b0;
          if (!res_lvl)
            manual_type <= ~nmi_lvl;
          // Watchdog start waits for a high pin; a held pin reset wins
          if (res_rise || (wdt_go && res_lvl)) begin
            wdt_go <= 1'b0;
            level_a <= 8'h00;
            level_b <= 8'h00;
            level_c <= 8'h00;
            sense_high <= 8'h00;
            sense_low <= 8'h00;
            req_enable <= 8'h00;
            req_flags <= 8'h00;
            sys_ctrl <= `RTIM_SYSTEM_CONTROL_RESET;
            mstop <= `RTIM_MSTOP_RESET;
            periph_reset_o <= 1'b1;
            port_reset_o <= ~manual_type;
            pins_to_port_o <= 1'b1;
            set_mask_o <= 1'b1;
            vec_num_o <= manual_type ? `RTIM_VEC_MANUAL : `RTIM_VEC_POWER_ON;
            vec_addr_o <= vec_addr(manual_type ? `RTIM_VEC_MANUAL : `RTIM_VEC_POWER_ON,
              advanced_mode_i);
            vec_valid_o <= 1'b1;
            state <= ST_VECTOR;
          end
        end
        ST_VECTOR: begin
          periph_reset_o <= 1'b0;
          port_reset_o <= 1'b0;
          pins_to_port_o <= 1'b0;
          cpu_halt_o <= 1'b0;
          if (vec_ack_i) begin
            vec_valid_o <= 1'b0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!vec_valid_o && !blocked && res_lvl && !wdt_overflow_i) begin
            if (nmi_pend || nmi_edge) begin
              nmi_pend <= 1'b0;
              vec_num_o <= `RTIM_VEC_NMI;
              vec_addr_o <= vec_addr(`RTIM_VEC_NMI, advanced_mode_i);
              vec_valid_o <= 1'b1;
              set_mask_o <= 1'b1;
              set_user_mask_o <= mode1;
            end else if (pick_ok) begin
              vec_num_o <= pick;
              vec_addr_o <= vec_addr(pick, advanced_mode_i);
              vec_valid_o <= 1'b1;
              set_mask_o <= 1'b1;
              set_user_mask_o <= mode1;
              if (pick >= `RTIM_VEC_EXT_BASE && pick < `RTIM_VEC_INT_BASE &&
                  (sense_all[{pick[2:0], 1'b0} +: 2] != 2'b00 || irq_lvl[pick[2:0]]))
                // Fresh event in the same cycle keeps the flag set
                req_flags[pick[2:0]] <= edge_hit(sense_all[{pick[2:0], 1'b0} +: 2],
                  irq_now[pick[2:0]], irq_lvl[pick[2:0]]);
            end else if (trap_pend) begin
              trap_pend <= 1'b0;
              vec_num_o <= `RTIM_VEC_TRAP_BASE + {5'h00, trap_num};
              vec_addr_o <= vec_addr(`RTIM_VEC_TRAP_BASE + {5'h00, trap_num},
                advanced_mode_i);
              vec_valid_o <= 1'b1;
              set_mask_o <= 1'b1;
              set_user_mask_o <= mode1;
            end
          end else if (vec_valid_o && vec_ack_i)
            vec_valid_o <= 1'b0;
          if (!res_lvl || wdt_overflow_i) begin
            state <= ST_RESET;
            cpu_halt_o <= 1'b1;
            if (wdt_overflow_i) begin
              manual_type <= wdt_manual_i;
              wdt_go <= 1'b1;
            end
          end
        end
        default: state <= ST_RESET;
      endcase
    end
  end

endmodule // rtim_core

// ---- rtim_core_checker.sv ----
/*
 Port checker for the exception front end.
 Bound to rtim_core by the bench; sees only that module's ports.
*/
module rtim_core_checker (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire reset_in_n_i,
  input wire advanced_mode_i,
  input wire trap_exec_i,
  input wire [1:0] trap_num_i,
  input wire vec_ack_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire avs_waitrequest_o,
  input wire cpu_halt_o,
  input wire vec_valid_o,
  input wire [6:0] vec_num_o,
  input wire [8:0] vec_addr_o,
  input wire set_mask_o,
  input wire set_user_mask_o,
  input wire [15:0] stack_addr_o,
  input wire [15:0] module_stop_ctrl_o,
  input wire [1:0] ctrl_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_stack_even: assert property (stack_addr_o[0] == 1'b0)
    else $error("stack address odd");
  // Six samples covers the pin filter delay
  a_halt_in_reset: assert property ((!reset_in_n_i)[*6] |-> cpu_halt_o)
    else $error("running while reset pin low");
  a_reset_state: assert property ($fell(cpu_halt_o) |->
    ctrl_mode_o == 2'b00 && module_stop_ctrl_o == 16'h3fff)
    else $error("state wrong at reset release");
  a_mask_on_vec: assert property ($rose(vec_valid_o) |-> set_mask_o)
    else $error("mask not set with vector");
  a_vec_entry: assert property (vec_valid_o |-> vec_addr_o ==
    (advanced_mode_i ? {vec_num_o, 2'b00} : {1'b0, vec_num_o, 1'b0}))
    else $error("vector entry address wrong");
  a_vec_held: assert property (vec_valid_o && !vec_ack_i && reset_in_n_i |=>
    vec_valid_o && $stable(vec_num_o))
    else $error("vector dropped before ack");
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o)
    else $error("bus answer late");
  a_trap_vec: assert property (trap_exec_i && !vec_valid_o && !cpu_halt_o |->
    ##[1:8] (vec_valid_o && vec_num_o == {5'h02, trap_num_i}))
    else $error("trap vector missing");
  a_user_mask: assert property ($rose(vec_valid_o) && vec_num_o[6:2] == 5'h02 |->
    set_user_mask_o == (ctrl_mode_o == 2'b01))
    else $error("user mask wrong after trap");
endmodule // rtim_core_checker

// ---- rtim_core_tb.sv ----
/*
 Self-checking bench for rtim_core: register map, reset types, traps,
 pin and nonmaskable vectors. Pins come from rtim_pin_model.
*/
module rtim_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, arst_n_i = 0, advanced_mode_i = 0, trap_exec_i = 0;
  logic sp_init_i = 0, vec_ack_i = 0, cpu_mask_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic wdt_overflow_i = 0, wdt_manual_i = 0, cpu_user_mask_i = 0;
  logic [19:0] int_req_i = 0, int_level_i = 0;
  logic [1:0] trap_num_i = 0;
  logic [15:0] stack_addr_i = 0, avs_address_i = 0;
  logic [7:0] avs_writedata_i = 0;
  wire reset_in_n_i, nmi_pin_i, avs_waitrequest_o, avs_response_err_o, cpu_halt_o;
  wire periph_reset_o, port_reset_o, pins_to_port_o, vec_valid_o, set_mask_o, set_user_mask_o;
  wire [7:0] ext_request_pins_i, avs_readdata_o;
  wire [6:0] vec_num_o;
  wire [8:0] vec_addr_o;
  wire [15:0] stack_addr_o, module_stop_ctrl_o;
  wire [1:0] ctrl_mode_o;
  int num_errors = 0, cmp_count = 0;
  logic [31:0] seed = 32'h4e74;
  logic [8:0] rd_q[$];
  logic [6:0] vec_q[$];
  logic [15:0] offs[10] = '{16'hfec0, 16'hfec1, 16'hfec2, 16'hff2c, 16'hff2d, 16'hff2e,
    16'hff2f, 16'hff39, 16'hff3e, 16'hff3c};
  logic [7:0] rstv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h3f};
  rtim_pin_model pins (.clk_i(clk_sys_i), .reset_in_n_o(reset_in_n_i), .nmi_o(nmi_pin_i),
    .ext_o(ext_request_pins_i));
  rtim_core dut (.clk_sys_i, .arst_n_i, .reset_in_n_i, .nmi_pin_i, .ext_request_pins_i,
    .wdt_overflow_i, .wdt_manual_i, .advanced_mode_i, .int_req_i,
    .int_level_i, .trap_exec_i, .trap_num_i, .sp_init_i, .vec_ack_i, .stack_addr_i,
    .cpu_mask_i, .cpu_user_mask_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_err_o, .cpu_halt_o,
    .periph_reset_o, .port_reset_o, .pins_to_port_o, .vec_valid_o, .vec_num_o, .vec_addr_o,
    .set_mask_o, .set_user_mask_o, .stack_addr_o, .module_stop_ctrl_o, .ctrl_mode_o);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished, errors so far %0d", s, num_errors);
  endtask
  // Holds the request until waitrequest is seen low; the watchdog cuts a hang
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // Unmapped offsets answer with the error flag set
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic err;
    err = (a != 16'hff3d);
    foreach (offs[k])
      if (offs[k] == a)
        err = 1'b0;
    rd_q.push_back({err, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      chk("readdata", 16'(rd_q[0][7:0]), 16'(avs_readdata_o));
      chk("resp err", 16'(rd_q[0][8]), 16'(avs_response_err_o));
      void'(rd_q.pop_front());
    end
    if (vec_valid_o === 1'b1 && !vec_ack_i) begin
      if (vec_q.size() == 0)
        chk("spare vector", 16'h0, 16'(vec_num_o));
      else begin
        chk("vector", 16'(vec_q[0]), 16'(vec_num_o));
        if (vec_q[0] < 7'h02) begin
          chk("port reset", 16'(vec_q[0] == 7'h00), 16'(port_reset_o));
          chk("periph reset", 16'h1, 16'(periph_reset_o));
          chk("pins to port", 16'h1, 16'(pins_to_port_o));
        end
        void'(vec_q.pop_front());
      end
      vec_ack_i <= 1'b1;
    end else
      vec_ack_i <= 1'b0;
  end
  initial forever #10 clk_sys_i = ~clk_sys_i;
  initial begin
    #(20 * 20000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    wt(3);
    arst_n_i <= 1'b1;
    vec_q.push_back(7'h00);
    pins.hold_reset(1'b1, 20);
    wt(30);
    chk("mode", 16'h0, 16'(ctrl_mode_o));
    chk("module stop", 16'h3fff, module_stop_ctrl_o);
    for (int i = 0; i < 10; i++) rd(offs[i], rstv[i]);
    rd(16'h0000, 8'h00);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      seed = nxt(seed);
      stack_addr_i <= seed[15:0] | 16'h0001;
      bus(1'b1, offs[i], seed[7:0]);
      chk("stack", {seed[15:1], 1'b0}, stack_addr_o);
      rd(offs[i], seed[7:0]);
      bus(1'b1, offs[i], 8'h00);
    end
    done("registers");
    sp_init_i <= 1'b1;
    wt(1);
    sp_init_i <= 1'b0;
    bus(1'b1, 16'hff2d, 8'h01);
    pins.set_lines(1'b1, 8'hfe);
    wt(8);
    rd(16'hff2f, 8'h01);
    bus(1'b1, 16'hff2f, 8'hff);
    rd(16'hff2f, 8'h01);
    bus(1'b1, 16'hff2f, 8'hfe);
    rd(16'hff2f, 8'h00);
    pins.set_lines(1'b1, 8'hff);
    bus(1'b1, 16'hff2d, 8'h40);
    bus(1'b1, 16'hff2e, 8'h08);
    vec_q.push_back(7'd19);
    pins.set_lines(1'b1, 8'hf7);
    wt(20);
    pins.set_lines(1'b1, 8'hff);
    bus(1'b1, 16'hff2e, 8'h00);
    done("pins");
    cpu_mask_i <= 1'b1;
    vec_q.push_back(7'd7);
    pins.set_lines(1'b0, 8'hff);
    wt(20);
    pins.set_lines(1'b1, 8'hff);
    done("nonmaskable");
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 16'hff39, m ? 8'h11 : 8'h01);
      advanced_mode_i <= m[0];
      for (int n = 0; n < 4; n++) begin
        vec_q.push_back(7'(8 + n));
        @(posedge clk_sys_i);
        trap_exec_i <= 1'b1;
        trap_num_i <= n[1:0];
        wt(1);
        trap_exec_i <= 1'b0;
        wt(12);
      end
    end
    bus(1'b1, 16'hff39, 8'h21);
    rd(16'hff39, 8'h11);
    chk("mode", 16'h1, 16'(ctrl_mode_o));
    done("traps");
    // Mode 1 with primary mask set: only level 1 sources get through
    cpu_user_mask_i <= 1'b0;
    int_level_i <= 20'h00004;
    for (int k = 0; k < 2; k++) begin
      if (k == 0)
        vec_q.push_back(7'd26);
      @(posedge clk_sys_i);
      int_req_i <= 20'h00004;
      wt(2);
      int_req_i <= 20'h0;
      wt(10);
      int_level_i <= 20'h0;
    end
    done("internal");
    wdt_manual_i <= 1'b1;
    vec_q.push_back(7'h01);
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b1;
    wt(1);
    wdt_overflow_i <= 1'b0;
    wt(10);
    rd(16'hff3d, 8'h0e);
    pins.set_lines(1'b0, 8'hff);
    wt(10);
    pins.set_lines(1'b1, 8'hff);
    wt(10);
    done("watchdog");
    bus(1'b1, 16'hfec0, 8'h5a);
    vec_q.push_back(7'h01);
    pins.hold_reset(1'b0, 25);
    wt(30);
    pins.set_lines(1'b1, 8'hff);
    rd(16'hfec0, 8'h00);
    rd(16'hff39, 8'h01);
    wt(20);
    chk("vectors left", 16'h0, 16'(vec_q.size()));
    done("manual reset");
    tally_and_finish();
  end
endmodule // rtim_core_tb

bind rtim_core rtim_core_checker chk_u (.clk_sys_i, .arst_n_i, .reset_in_n_i, .advanced_mode_i,
  .trap_exec_i, .trap_num_i, .vec_ack_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .cpu_halt_o, .vec_valid_o, .vec_num_o, .vec_addr_o, .set_mask_o, .set_user_mask_o,
  .stack_addr_o, .module_stop_ctrl_o, .ctrl_mode_o);

// ---- rtim_defs.vh ----
/*
 Constants for the exception front end: register offsets, reset values,
 field positions, vector numbers and timing counts. Definitions only.
*/
`ifndef RTIM_DEFS_VH
`define RTIM_DEFS_VH

`define RTIM_OFS_LEVEL_A 16'hfec0
`define RTIM_OFS_LEVEL_B 16'hfec1
`define RTIM_OFS_LEVEL_C 16'hfec2
`define RTIM_OFS_SENSE_HIGH 16'hff2c
`define RTIM_OFS_SENSE_LOW 16'hff2d
`define RTIM_OFS_REQ_ENABLE 16'hff2e
`define RTIM_OFS_REQ_FLAGS 16'hff2f
`define RTIM_OFS_SYS_CTRL 16'hff39
`define RTIM_OFS_EXC_CTRL 16'hff3c
`define RTIM_OFS_EXC_STATUS 16'hff3d
`define RTIM_OFS_MODULE_STOP 16'hff3e

`define RTIM_SYSTEM_CONTROL_RESET 8'h01
`define RTIM_SYSTEM_CONTROL_WMASK 8'hf9
`define RTIM_MSTOP_RESET 16'h3fff
`define RTIM_SYSTEM_CONTROL_MODE_HI 5
`define RTIM_SYSTEM_CONTROL_MODE_LO 4
`define RTIM_SYSTEM_CONTROL_NMI_EDGE 3

`define RTIM_VEC_POWER_ON 7'h00
`define RTIM_VEC_MANUAL 7'h01
`define RTIM_VEC_NMI 7'h07
`define RTIM_VEC_TRAP_BASE 7'h08
`define RTIM_VEC_EXT_BASE 7'h10
`define RTIM_VEC_INT_BASE 7'h18
`define RTIM_VEC_INT_LAST 7'h5b

`define RTIM_CLK_MHZ 50
`define RTIM_RUN_RESET_STATES 20
`define RTIM_POWERUP_RESET_MS 20

`endif

// ---- rtim_pin_model.sv ----
/*
 Board side model: reset pin, nonmaskable pin and request pins.
 Driven by task calls; lines change just after a clock edge.
*/
module rtim_pin_model (
  input wire logic clk_i,
  output logic reset_in_n_o,
  output logic nmi_o,
  output logic [7:0] ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reset_in_n_o = 1'b0;
    nmi_o = 1'b1;
    ext_o = 8'hff;
  end
  // Pin level moves a cycle after reset so no stray edge is taken first
  task automatic hold_reset(input logic nmi_lvl, input int states);
    @(posedge clk_i);
    reset_in_n_o <= 1'b0;
    @(posedge clk_i);
    nmi_o <= nmi_lvl;
    repeat ((states < 20) ? 20 : states) @(posedge clk_i);
    reset_in_n_o <= 1'b1;
  endtask
  task automatic set_lines(input logic nmi_lvl, input logic [7:0] ext);
    @(posedge clk_i);
    nmi_o <= nmi_lvl;
    ext_o <= ext;
  endtask
endmodule // rtim_pin_model
